// ### src/psr_burst_ctr.sv
`timescale 1ns/100ps
`default_nettype none
module psr_burst_ctr (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // burst control
    psr_burst_if.ctr b
);

    typedef struct packed {
        logic [psr_pkg::CNT_W-1:0] start;
        logic [psr_pkg::CNT_W-1:0] cnt;
    } psr_ctr_t;

    psr_ctr_t s_r;
    psr_ctr_t s_nxt;

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (b.load) begin
            s_nxt.start = b.start;
            s_nxt.cnt = psr_pkg::CNT_RST;
        end else if (b.step) begin
            s_nxt.cnt = psr_pkg::CNT_W'(s_r.cnt + 2'h1);
        end
    end

    // the access in a loading cycle uses the new start bits directly
    assign b.off = b.load ? b.start : psr_pkg::burst_off(s_r.start, s_nxt.cnt, b.linear);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_start_preload: assert property (@(posedge clk) disable iff (!arst_n)
        b.load |=> (s_r.start == $past(b.start)) && (s_r.cnt == 2'h0))
        else $error("start bits not preloaded");

    a_step_only_adv: assert property (@(posedge clk) disable iff (!arst_n)
        (!b.load && !b.step) |=> $stable(s_r.cnt))
        else $error("counter moved without advance");

    a_wrap_four: assert property (@(posedge clk) disable iff (!arst_n)
        b.load ##1 (b.step && !b.load)[*4] |-> b.off == $past(b.off, 4))
        else $error("burst did not wrap to start");

endmodule // psr_burst_ctr
`default_nettype wire

// ### src/psr_burst_if.sv
`timescale 1ns/100ps
`default_nettype none
interface psr_burst_if;
    logic load;
    logic [psr_pkg::CNT_W-1:0] start;
    logic step;
    logic linear;
    logic [psr_pkg::CNT_W-1:0] off;

    modport ctr (input load, input start, input step, input linear, output off);
    modport user (output load, output start, output step, output linear, input off);
endinterface
`default_nettype wire

// ### src/psr_pkg.sv
// Operation
// - every synchronous input is captured on the rising clock edge
// - address and chip selects load only when an address strobe is taken
// - later burst addresses come from the counter, stepping only when advance is low
// - the burst counter is two bits, covering at most four locations
// - a static input selects interleaved or linear burst order
// - write address, data and controls are registered, then written without host timing
// - a byte write updates only the lanes whose select is low
// - global write low writes every lane regardless of lane controls
// - after a deselect the data drivers stay on for one more clock
// - output enable and sleep act on the drivers without a clock edge
// - burst read gives first word two clocks after start, then one per clock
// - array holds 256K words of 36 bits in four lanes
// - when both strobes are low and the pipelined select is low, only the processor strobe counts
// - a new address preloads its two low bits into the burst counter
// - output enable is masked in the first clock of a read after deselect
package psr_pkg;

    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DATA_W = 36;
    localparam int unsigned LANES = 4;
    localparam int unsigned LANE_W = 9;
    localparam int unsigned DEPTH = 262144;
    localparam int unsigned CNT_W = 2;
    localparam int unsigned BASE_W = ADDR_W - CNT_W;

    localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
    localparam logic [LANES-1:0] LANES_ALL = 4'hf;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
    localparam logic [BASE_W-1:0] BASE_RST = 16'h0;

    // burst offset from start bits and beat count, wrapping in two bits
    function automatic logic [CNT_W-1:0] burst_off(
        input logic [CNT_W-1:0] start,
        input logic [CNT_W-1:0] cnt,
        input logic linear
    );
        burst_off = linear ? CNT_W'(start + cnt) : (start ^ cnt);
    endfunction

endpackage

// ### src/psr_port.sv
`timescale 1ns/100ps
`default_nettype none
module psr_port (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // address and strobes
    input wire logic [psr_pkg::ADDR_W-1:0] addr,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_step_n,
    // chip selects
    input wire logic pipelined_select_n,
    input wire logic depth_select_hi,
    input wire logic depth_select_lo_n,
    // write controls
    input wire logic all_bytes_write_n,
    input wire logic byte_write_gate_n,
    input wire logic [psr_pkg::LANES-1:0] lane_select_n,
    // asynchronous controls and static mode
    input wire logic out_enable_n,
    input wire logic sleep_request,
    input wire logic burst_linear,
    // data pins, each lane carries its parity_lane bit on top
    input wire logic [psr_pkg::DATA_W-1:0] dq_i,
    output logic [psr_pkg::DATA_W-1:0] dq_o,
    output logic dq_oe_n
);

    typedef struct packed {
        logic [psr_pkg::ADDR_W-1:0] addr;
        logic [psr_pkg::DATA_W-1:0] dq;
        logic processor_addr_strobe_n_n;
        logic controller_addr_strobe_n_n;
        logic adv_n;
        logic gw_n;
        logic bwe_n;
        logic [psr_pkg::LANES-1:0] bw_n;
        logic ce1_n;
        logic ce2;
        logic ce3_n;
    } psr_pins_t;

    typedef struct packed {
        psr_pins_t in;
        logic sel;
        logic [psr_pkg::BASE_W-1:0] base;
        logic rd_v;
        logic desel_v;
        logic [psr_pkg::DATA_W-1:0] rd_data;
        logic out_v;
        logic [psr_pkg::DATA_W-1:0] out_data;
        logic hold;
    } psr_state_t;

    localparam psr_pins_t PINS_IDLE = '{
        addr: '0, dq: psr_pkg::DATA_RST, processor_addr_strobe_n_n: 1'b1, controller_addr_strobe_n_n: 1'b1, adv_n: 1'b1,
        gw_n: 1'b1, bwe_n: 1'b1, bw_n: psr_pkg::LANES_ALL, ce1_n: 1'b1, ce2: 1'b0,
        ce3_n: 1'b1};

    psr_state_t s_r;
    psr_state_t s_nxt;
    logic [psr_pkg::DATA_W-1:0] mem [0:psr_pkg::DEPTH-1];

    logic processor_addr_strobe_n_take;
    logic load;
    logic chip_on;
    logic active;
    logic [psr_pkg::LANES-1:0] req_lanes;
    logic [psr_pkg::LANES-1:0] wr_lanes;
    logic wr;
    logic rd;
    logic [psr_pkg::ADDR_W-1:0] cur_addr;

    psr_burst_if b ();

    psr_burst_ctr u_ctr (
        .clk(clk),
        .arst_n(arst_n),
        .b(b)
    );

    // ----------------------------------------
    // decode of registered pins
    // ----------------------------------------
    // processor strobe is dropped while the pipelined select is high
    assign processor_addr_strobe_n_take = !s_r.in.processor_addr_strobe_n_n && !s_r.in.ce1_n;
    assign load = processor_addr_strobe_n_take || !s_r.in.controller_addr_strobe_n_n;
    assign chip_on = !s_r.in.ce1_n && s_r.in.ce2 && !s_r.in.ce3_n;
    assign active = load ? chip_on : s_r.sel;
    assign req_lanes = !s_r.in.gw_n ? psr_pkg::LANES_ALL :
                       (!s_r.in.bwe_n ? ~s_r.in.bw_n : psr_pkg::LANES_NONE);
    // a processor strobe cycle never writes, even if the controller strobe is low too
    assign wr_lanes = (active && !processor_addr_strobe_n_take) ? req_lanes : psr_pkg::LANES_NONE;
    assign wr = |wr_lanes;
    assign rd = active && !wr;

    assign b.load = load;
    assign b.start = s_r.in.addr[psr_pkg::CNT_W-1:0];
    assign b.step = !load && s_r.sel && !s_r.in.adv_n;
    assign b.linear = burst_linear;
    assign cur_addr = load ? s_r.in.addr : {s_r.base, b.off};

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.in = '{addr: addr, dq: dq_i, processor_addr_strobe_n_n: processor_addr_strobe_n,
                     controller_addr_strobe_n_n: controller_addr_strobe_n, adv_n: burst_step_n,
                     gw_n: all_bytes_write_n, bwe_n: byte_write_gate_n,
                     bw_n: lane_select_n, ce1_n: pipelined_select_n,
                     ce2: depth_select_hi, ce3_n: depth_select_lo_n};
        if (load) begin
            s_nxt.sel = chip_on;
            s_nxt.base = s_r.in.addr[psr_pkg::ADDR_W-1:psr_pkg::CNT_W];
        end
        s_nxt.rd_v = rd;
        s_nxt.desel_v = load && !chip_on;
        if (rd) begin
            s_nxt.rd_data = mem[cur_addr];
        end
        s_nxt.out_v = s_r.rd_v;
        if (s_r.rd_v) begin
            s_nxt.out_data = s_r.rd_data;
        end
        // extra enable stage: drivers linger one clock past a deselect
        s_nxt.hold = s_r.out_v && s_r.desel_v;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '{in: PINS_IDLE, sel: 1'b0, base: psr_pkg::BASE_RST, rd_v: 1'b0,
                     desel_v: 1'b0, rd_data: psr_pkg::DATA_RST, out_v: 1'b0,
                     out_data: psr_pkg::DATA_RST, hold: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // array write, one clock after the pins are registered
    // ----------------------------------------
    always_ff @(posedge clk) begin
        for (int l = 0; l < psr_pkg::LANES; l++) begin
            if (wr_lanes[l]) begin
                mem[cur_addr][l*psr_pkg::LANE_W +: psr_pkg::LANE_W] <=
                    s_r.in.dq[l*psr_pkg::LANE_W +: psr_pkg::LANE_W];
            end
        end
    end

    // ----------------------------------------
    // output drivers
    // ----------------------------------------
    // drivers follow read data only, so a read out of deselect keeps them off
    // for its first clock whatever output enable says
    assign dq_o = s_r.out_data;
    assign dq_oe_n = !((s_r.out_v || s_r.hold) && !out_enable_n && !sleep_request);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_first_word: assert property (@(posedge clk) disable iff (!arst_n)
        rd |-> ##2 (s_r.out_v && dq_o == $past(mem[cur_addr], 2)))
        else $error("read data not out two clocks after decode");

    a_dcd_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (s_r.out_v && s_r.desel_v) |=> (s_r.hold && !s_r.out_v) ##1 !s_r.hold)
        else $error("drivers not held exactly one clock after deselect");

    a_async_off: assert property (@(posedge clk) disable iff (!arst_n)
        (out_enable_n || sleep_request) |-> dq_oe_n)
        else $error("drivers on while disabled");

    a_global_write: assert property (@(posedge clk) disable iff (!arst_n)
        (active && !processor_addr_strobe_n_take && !s_r.in.gw_n) |-> wr_lanes == psr_pkg::LANES_ALL)
        else $error("global write missed a lane");

    a_lane_write: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && s_r.in.gw_n) |-> (!s_r.in.bwe_n && wr_lanes == ~s_r.in.bw_n))
        else $error("byte write lanes wrong");

    a_processor_addr_strobe_n_wins: assert property (@(posedge clk) disable iff (!arst_n)
        (processor_addr_strobe_n_take && !s_r.in.controller_addr_strobe_n_n) |-> !wr)
        else $error("controller strobe honoured over processor strobe");

    a_load_gate: assert property (@(posedge clk) disable iff (!arst_n)
        !load |=> ($stable(s_r.base) && $stable(s_r.sel)))
        else $error("address loaded without strobe");

    a_read_off_first: assert property (@(posedge clk) disable iff (!arst_n)
        (rd && load && !s_r.sel && !s_r.out_v && !s_r.hold) |=> dq_oe_n)
        else $error("drivers on in first clock after deselect");

    a_pins_taken: assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |=> (s_r.in.addr == $past(addr)) && (s_r.in.dq == $past(dq_i)))
        else $error("pins not registered on the rising edge");

    a_desel_idle: assert property (@(posedge clk) disable iff (!arst_n)
        (load && !chip_on) |=> (!s_r.sel && !s_r.rd_v))
        else $error("deselect still accessed the array");

    a_burst_block: assert property (@(posedge clk) disable iff (!arst_n)
        b.step |-> (cur_addr[psr_pkg::ADDR_W-1:psr_pkg::CNT_W] ==
                    $past(cur_addr[psr_pkg::ADDR_W-1:psr_pkg::CNT_W])))
        else $error("burst left its four-word block");

    // array side: whole-word writes are checked here, single lanes by the bench
    // through read-back
    a_write_lands: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_lanes == psr_pkg::LANES_ALL) |=> (mem[$past(cur_addr)] == $past(s_r.in.dq)))
        else $error("global write not stored");

    a_gate_needed: assert property (@(posedge clk) disable iff (!arst_n)
        (s_r.in.gw_n && s_r.in.bwe_n) |-> !wr)
        else $error("write without byte gate");

    a_drive_needs_data: assert property (@(posedge clk) disable iff (!arst_n)
        !dq_oe_n |-> (s_r.out_v || s_r.hold))
        else $error("drivers on with no read data");

    a_out_holds: assert property (@(posedge clk) disable iff (!arst_n)
        !s_r.rd_v |=> $stable(dq_o))
        else $error("read data changed without a read");

endmodule // psr_port
`default_nettype wire

// ### tb/psr_host.sv
`timescale 1ns/100ps
`default_nettype none
module psr_host (
    // clock
    input wire logic clk
);
    // ----------------------------------------
    // bus pins, changed just after each edge
    // ----------------------------------------
    logic [psr_pkg::ADDR_W-1:0] addr = 18'h0;
    logic p_stb_n = 1'b1;
    logic c_stb_n = 1'b1;
    logic step_n = 1'b1;
    logic sel_n = 1'b1;
    logic sel_hi = 1'b0;
    logic sel_lo_n = 1'b1;
    logic all_n = 1'b1;
    logic gate_n = 1'b1;
    logic [psr_pkg::LANES-1:0] lane_n = 4'hf;
    logic [psr_pkg::DATA_W-1:0] dq = 36'h0;

    // stb is {processor, controller}, active low
    task automatic cyc(input logic [psr_pkg::ADDR_W-1:0] a, input logic [1:0] stb,
                       input logic on, input logic st_n, input logic w_n,
                       input logic g_n, input logic [psr_pkg::LANES-1:0] l_n,
                       input logic [psr_pkg::DATA_W-1:0] d);
        p_stb_n = stb[1];
        c_stb_n = stb[0];
        // lines nobody qualifies toggle, so a stale value never looks valid
        addr = (&stb) ? ~addr : a;
        sel_n = ~on;
        sel_hi = on;
        sel_lo_n = ~on;
        step_n = st_n;
        all_n = w_n;
        gate_n = g_n;
        lane_n = l_n;
        dq = (w_n & g_n) ? ~dq : d;
        @(posedge clk);
        #1;
    endtask
endmodule // psr_host
`default_nettype wire

// ### tb/tb_pipelined_burst_sync_sram_port.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pipelined_burst_sync_sram_port;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic oe_n = 1'b0;
    logic sleep = 1'b0;
    logic linear = 1'b0;
    logic [35:0] dq_o;
    logic dq_oe_n;
    int num_errors = 0;
    int cmp_count = 0;
    logic [35:0] mem [int];

    initial begin
        forever #2.5 clk = ~clk;
    end

    psr_host host (.clk(clk));

    psr_port dut (
        .clk(clk),
        .arst_n(arst_n),
        .addr(host.addr),
        .processor_addr_strobe_n(host.p_stb_n),
        .controller_addr_strobe_n(host.c_stb_n),
        .burst_step_n(host.step_n),
        .pipelined_select_n(host.sel_n),
        .depth_select_hi(host.sel_hi),
        .depth_select_lo_n(host.sel_lo_n),
        .all_bytes_write_n(host.all_n),
        .byte_write_gate_n(host.gate_n),
        .lane_select_n(host.lane_n),
        .out_enable_n(oe_n),
        .sleep_request(sleep),
        .burst_linear(linear),
        .dq_i(host.dq),
        .dq_o(dq_o),
        .dq_oe_n(dq_oe_n)
    );

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ----------------------------------------
    // write through the controller strobe
    // ----------------------------------------
    task automatic wr(input int a, input logic w_n, input logic [3:0] l_n);
        logic [35:0] d;
        d = 36'({$urandom, $urandom});
        // no lane at all would turn into a read and keep drivers on
        if (&l_n) l_n = 4'he;
        host.cyc(18'(a), 2'h2, 1'b1, 1'b1, w_n, 1'b0, l_n, d);
        for (int l = 0; l < 4; l++)
            if (!w_n || !l_n[l]) mem[a][9*l +: 9] = d[9*l +: 9];
    endtask

    // mode 0 processor, 1 controller, 2 both strobes
    task automatic burst(input int a, input int mode);
        int s;
        int e;
        s = a & 3;
        // five beats: the last one checks the wrap back to the start word
        for (int i = 0; i < 9; i++) begin
            case (i)
                0: host.cyc(18'(a), mode == 0 ? 2'h1 : mode == 1 ? 2'h2 : 2'h0, 1'b1, 1'b1,
                            mode == 1, 1'b1, 4'hf, 36'({$urandom, $urandom}));
                5: host.cyc(18'h0, 2'h2, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 36'h0);
                default: host.cyc(18'h0, 2'h3, 1'b1, i > 4, 1'b1, 1'b1, 4'hf, 36'h0);
            endcase
            if (i > 1 && i < 7) begin
                e = (a & ~3) | (linear ? (s + i - 2) & 3 : s ^ ((i - 2) & 3));
                chk(dq_o, mem[e], "read data");
                chk(36'(dq_oe_n), 36'h0, "drive on");
            end
            if (i == 1 || i == 8) chk(36'(dq_oe_n), 36'h1, "drive off");
            if (i == 7) chk(36'(dq_oe_n), 36'h0, "drive hold");
            if (i == 3) begin
                oe_n = 1'b1;
                #0.5 chk(36'(dq_oe_n), 36'h1, "oe async");
                oe_n = 1'b0;
                sleep = 1'b1;
                #0.5 chk(36'(dq_oe_n), 36'h1, "sleep async");
                // kept over the next edge so the clocked check sees it as well
                sleep <= #3.5 1'b0;
            end
        end
    endtask

    task automatic results();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        int a;
        void'($urandom(39));
        repeat (16) @(posedge clk);
        #1 arst_n = 1'b1;
        chk(36'(dq_oe_n), 36'h1, "reset drive");
        chk(dq_o, 36'h0, "reset data");
        for (int t = 0; t < 12; t++) begin
            a = int'($urandom % 262144);
            linear = t[0];
            for (int k = 0; k < 4; k++) wr((a & ~3) | k, 1'b0, 4'($urandom));
            repeat (4) wr((a & ~3) | int'($urandom % 4), 1'b1, 4'($urandom));
            // deselect so the read starts from the idle state
            host.cyc(18'h0, 2'h2, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 36'h0);
            burst(a, t % 3);
        end
        results();
    end
endmodule // tb_pipelined_burst_sync_sram_port
`default_nettype wire
